// ===== rtl/adprp_pkg.sv
package adprp_pkg;

  // array shape
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // clock and pin timing, slowest grade
  localparam int CLK_NS  = 100;
  localparam int WP_NS   = 60;  // minimum write pulse
  localparam int TAA_NS  = 70;  // address and select access
  localparam int THZ_NS  = 30;  // output turn-off after deselect
  localparam int TDH_NS  = 3;   // data hold after write end
  localparam int PTP_NS  = 90;  // port-to-port write-to-read delay

  // least times round up, never below one cycle
  localparam int WP_CYC  = ((WP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TAA_CYC = ((TAA_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                           : (TAA_NS + CLK_NS - 1) / CLK_NS;
  localparam int THZ_CYC = ((THZ_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                           : (THZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int TDH_CYC = ((TDH_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                           : (TDH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PTP_CYC = ((PTP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                           : (PTP_NS + CLK_NS - 1) / CLK_NS;

  localparam int CNT_W = 4;

  // per-port sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SETUP = 6'h02,
    ST_WPUL  = 6'h04,
    ST_WHOLD = 6'h08,
    ST_RACC  = 6'h10,
    ST_TURN  = 6'h20
  } adprp_state_t;

endpackage : adprp_pkg

// ===== rtl/adprp_port_seq.sv
`timescale 1ns/1ns
`default_nettype none
module adprp_port_seq #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // user request side
  input  wire logic          req,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          go,
  output logic               ready,
  output logic               done,
  output logic [DW-1:0]      rdata,
  // status toward the arbiter
  output logic               busy,
  output logic               is_write,
  // ram pins
  output logic               pin_sel_n,
  output logic               pin_rw,
  output logic               pin_oe_n,
  output logic [AW-1:0]      pin_addr,
  output logic [DW-1:0]      pin_data_out,
  output logic               pin_data_oe_n,
  input  wire logic [DW-1:0] pin_data_in
);

  ////////////////////////////////////////////////////////////////////////////
  adprp_pkg::adprp_state_t state;
  adprp_pkg::adprp_state_t next_state;
  logic [adprp_pkg::CNT_W-1:0] cnt;
  logic [adprp_pkg::CNT_W-1:0] next_cnt;

  localparam logic [adprp_pkg::CNT_W-1:0] WP_LD  = adprp_pkg::CNT_W'(adprp_pkg::WP_CYC - 1);
  localparam logic [adprp_pkg::CNT_W-1:0] TAA_LD = adprp_pkg::CNT_W'(adprp_pkg::TAA_CYC - 1);
  localparam logic [adprp_pkg::CNT_W-1:0] THZ_LD = adprp_pkg::CNT_W'(adprp_pkg::THZ_CYC - 1);
  localparam logic [adprp_pkg::CNT_W-1:0] TDH_LD = adprp_pkg::CNT_W'(adprp_pkg::TDH_CYC - 1);

  wire idle    = (state == adprp_pkg::ST_IDLE);
  wire cnt_end = (cnt == '0);
  wire start   = idle && req && go;
  wire capture = (state == adprp_pkg::ST_RACC) && cnt_end;

  // handshake and status
  assign ready    = idle && go;
  assign busy     = !idle;
  assign done     = ((state == adprp_pkg::ST_WHOLD) || (state == adprp_pkg::ST_TURN)) && cnt_end;

  // pins straight from the state register; output enable only low in a read,
  // so the ram never drives during a write and the short pulse is enough
  assign pin_sel_n     = !((state == adprp_pkg::ST_WPUL) || (state == adprp_pkg::ST_RACC));
  assign pin_rw        = (state != adprp_pkg::ST_WPUL);
  assign pin_oe_n      = (state != adprp_pkg::ST_RACC);
  assign pin_data_oe_n = !((state == adprp_pkg::ST_WPUL) || (state == adprp_pkg::ST_WHOLD));

  // next state; address is set up a cycle early with select and rw high
  always_comb begin
    next_state = state;
    next_cnt   = cnt_end ? cnt : cnt - 1'b1;
    unique case (state)
      adprp_pkg::ST_IDLE: begin
        if (start) next_state = adprp_pkg::ST_SETUP;
      end
      adprp_pkg::ST_SETUP: begin
        // on a write, select and rw fall together so outputs stay off
        next_state = is_write ? adprp_pkg::ST_WPUL : adprp_pkg::ST_RACC;
        next_cnt   = is_write ? WP_LD : TAA_LD;
      end
      adprp_pkg::ST_WPUL: begin
        if (cnt_end) begin
          next_state = adprp_pkg::ST_WHOLD;
          next_cnt   = TDH_LD;
        end
      end
      adprp_pkg::ST_RACC: begin
        if (cnt_end) begin
          next_state = adprp_pkg::ST_TURN;
          next_cnt   = THZ_LD;
        end
      end
      adprp_pkg::ST_WHOLD, adprp_pkg::ST_TURN: begin
        if (cnt_end) next_state = adprp_pkg::ST_IDLE;
      end
      default: next_state = adprp_pkg::ST_IDLE;
    endcase
  end

  // state, counter, latched request, captured read data
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state        <= adprp_pkg::ST_IDLE;
      cnt          <= '0;
      is_write     <= 1'b0;
      pin_addr     <= '0;
      pin_data_out <= '0;
      rdata        <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (start) begin
        is_write     <= we;
        pin_addr     <= addr;
        pin_data_out <= wdata;
      end
      if (capture) rdata <= pin_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence wr_pulse_s;
    !pin_rw && !pin_sel_n && !pin_data_oe_n;
  endsequence
  sequence wr_end_s;
    pin_rw && pin_sel_n && !pin_data_oe_n;
  endsequence

  AST_ADDR_QUIET: assert property (@(posedge ref_clk) disable iff (srst)
    $changed(pin_addr) |-> pin_rw && pin_sel_n)
    else $error("address moved while select and rw were low");
  AST_WR_TOGETHER: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(pin_rw) |-> $fell(pin_sel_n) && pin_oe_n)
    else $error("write pulse did not open with select and rw together");
  AST_WR_SHAPE: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(pin_rw) |-> wr_pulse_s ##1 wr_end_s ##0 done)
    else $error("write pulse or data hold out of shape");
  AST_RD_SHAPE: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(pin_oe_n) |-> (!pin_sel_n && pin_rw && pin_data_oe_n) ##1 (pin_oe_n && done))
    else $error("read access or turnaround out of shape");
  AST_RD_CAPTURE: assert property (@(posedge ref_clk) disable iff (srst)
    !pin_oe_n |=> rdata == $past(pin_data_in))
    else $error("read data not captured at end of access");
  AST_NO_FIGHT: assert property (@(posedge ref_clk) disable iff (srst)
    !pin_data_oe_n |-> pin_oe_n)
    else $error("host drives data while ram outputs enabled");

endmodule : adprp_port_seq
`default_nettype wire

// ===== rtl/adprp_host.sv
`timescale 1ns/1ns
`default_nettype none
module adprp_host #(
  parameter int AW = adprp_pkg::ADDR_W,
  parameter int DW = adprp_pkg::DATA_W
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // left user port
  input  wire logic          left_req,
  input  wire logic          left_we,
  input  wire logic [AW-1:0] left_addr,
  input  wire logic [DW-1:0] left_wdata,
  output logic               left_ready,
  output logic               left_done,
  output logic [DW-1:0]      left_rdata,
  // right user port
  input  wire logic          right_req,
  input  wire logic          right_we,
  input  wire logic [AW-1:0] right_addr,
  input  wire logic [DW-1:0] right_wdata,
  output logic               right_ready,
  output logic               right_done,
  output logic [DW-1:0]      right_rdata,
  // left ram pins
  output logic               left_port_select_n,
  output logic               left_rw,
  output logic               left_oe_n,
  output logic [AW-1:0]      left_port_address,
  output logic [DW-1:0]      left_port_data_bus_out,
  output logic               left_port_data_bus_oe_n,
  input  wire logic [DW-1:0] left_port_data_bus_in,
  // right ram pins
  output logic               right_port_select_n,
  output logic               right_rw,
  output logic               right_oe_n,
  output logic [AW-1:0]      right_port_address,
  output logic [DW-1:0]      right_port_data_bus_out,
  output logic               right_port_data_bus_oe_n,
  input  wire logic [DW-1:0] right_port_data_bus_in,
  // power status
  output logic               left_standby,
  output logic               right_standby,
  output logic               full_power_down
);

  ////////////////////////////////////////////////////////////////////////////
  // clash test: same location with at least one writer
  function automatic logic addr_clash(input logic [AW-1:0] a, input logic [AW-1:0] b,
                                      input logic wa, input logic wb);
    addr_clash = (a == b) && (wa || wb);
  endfunction : addr_clash

  // settle window in cycles; loads the full count so a zero count means free
  localparam logic [adprp_pkg::CNT_W-1:0] PTP_LD = adprp_pkg::CNT_W'(adprp_pkg::PTP_CYC);

  // engine status and settle bookkeeping
  logic left_busy;
  logic right_busy;
  logic left_is_write;
  logic right_is_write;
  logic left_go;
  logic right_go;
  logic [adprp_pkg::CNT_W-1:0] left_hold;
  logic [adprp_pkg::CNT_W-1:0] right_hold;
  logic [AW-1:0] left_hold_addr;
  logic [AW-1:0] right_hold_addr;

  ////////////////////////////////////////////////////////////////////////////
  // the ram has no arbitration, so this side keeps the ports apart;
  // left wins a same-cycle tie, which can starve right under heavy traffic
  wire left_busy_clash  = right_busy && addr_clash(left_addr, right_port_address,
                                                   left_we, right_is_write);
  wire right_busy_clash = left_busy && addr_clash(right_addr, left_port_address,
                                                  right_we, left_is_write);
  wire left_start       = left_req && left_ready;
  wire right_start_w    = right_req && right_ready;
  wire right_tie        = left_start && addr_clash(right_addr, left_addr,
                                                   right_we, left_we);
  // a freshly written location is held off the other port until it settles
  wire left_settling    = (right_hold != '0) && (right_hold_addr == left_addr);
  wire right_settling   = (left_hold != '0) && (left_hold_addr == right_addr);

  assign left_go  = !left_busy_clash && !left_settling;
  assign right_go = !right_busy_clash && !right_tie && !right_settling;

  // standby whenever a port is deselected; both means full power-down
  assign left_standby    = left_port_select_n;
  assign right_standby   = right_port_select_n;
  assign full_power_down = left_port_select_n && right_port_select_n;

  ////////////////////////////////////////////////////////////////////////////
  // port-to-port settle counters, loaded as a write ends
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      left_hold       <= '0;
      right_hold      <= '0;
      left_hold_addr  <= '0;
      right_hold_addr <= '0;
    end else begin
      left_hold  <= (left_done && left_is_write) ? PTP_LD
                    : (left_hold != '0) ? left_hold - 1'b1 : left_hold;
      right_hold <= (right_done && right_is_write) ? PTP_LD
                    : (right_hold != '0) ? right_hold - 1'b1 : right_hold;
      if (left_done && left_is_write) left_hold_addr <= left_port_address;
      if (right_done && right_is_write) right_hold_addr <= right_port_address;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two identical, independent port engines
  adprp_port_seq #(.AW(AW), .DW(DW)) u_left (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .req           (left_req),
    .we            (left_we),
    .addr          (left_addr),
    .wdata         (left_wdata),
    .go            (left_go),
    .ready         (left_ready),
    .done          (left_done),
    .rdata         (left_rdata),
    .busy          (left_busy),
    .is_write      (left_is_write),
    .pin_sel_n     (left_port_select_n),
    .pin_rw        (left_rw),
    .pin_oe_n      (left_oe_n),
    .pin_addr      (left_port_address),
    .pin_data_out  (left_port_data_bus_out),
    .pin_data_oe_n (left_port_data_bus_oe_n),
    .pin_data_in   (left_port_data_bus_in)
  );

  adprp_port_seq #(.AW(AW), .DW(DW)) u_right (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .req           (right_req),
    .we            (right_we),
    .addr          (right_addr),
    .wdata         (right_wdata),
    .go            (right_go),
    .ready         (right_ready),
    .done          (right_done),
    .rdata         (right_rdata),
    .busy          (right_busy),
    .is_write      (right_is_write),
    .pin_sel_n     (right_port_select_n),
    .pin_rw        (right_rw),
    .pin_oe_n      (right_oe_n),
    .pin_addr      (right_port_address),
    .pin_data_out  (right_port_data_bus_out),
    .pin_data_oe_n (right_port_data_bus_oe_n),
    .pin_data_in   (right_port_data_bus_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  AST_NO_SHARED_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
    (left_busy && right_busy) |->
      !addr_clash(left_port_address, right_port_address, left_is_write, right_is_write))
    else $error("both ports active on one location with a write");
  AST_LEFT_SETTLE: assert property (@(posedge ref_clk) disable iff (srst)
    (left_done && left_is_write) |=> !(right_start_w && right_addr == $past(left_port_address)))
    else $error("right port entered a location still settling");
  AST_TIE_LEFT: assert property (@(posedge ref_clk) disable iff (srst)
    (left_start && right_req && addr_clash(left_addr, right_addr, left_we, right_we))
      |-> !right_ready ##1 left_busy)
    else $error("same-cycle clash not won by left");
  AST_POWER_DOWN: assert property (@(posedge ref_clk) disable iff (srst)
    (!left_busy && !right_busy) |-> full_power_down && left_port_data_bus_oe_n
                                    && right_port_data_bus_oe_n)
    else $error("idle ports not powered down and floating");

  ////////////////////////////////////////////////////////////////////////////
  // host-level view of the same hazards; the engines cannot see each other,
  // so only this level can tell a real overlap on the shared array
  localparam int PTP_DLY = adprp_pkg::PTP_CYC;

  sequence left_wr_end_s;
    left_done && left_is_write;
  endsequence
  sequence right_wr_end_s;
    right_done && right_is_write;
  endsequence
  sequence left_fresh_s;
    (left_hold == PTP_LD) ##PTP_DLY (left_hold == '0);
  endsequence
  sequence right_fresh_s;
    (right_hold == PTP_LD) ##PTP_DLY (right_hold == '0);
  endsequence

  AST_RIGHT_SETTLE: assert property (@(posedge ref_clk) disable iff (srst)
    (right_done && right_is_write) |=> !(left_start && left_addr == $past(right_port_address)))
    else $error("left port entered a location still settling");

  AST_LEFT_FRESH: assert property (@(posedge ref_clk) disable iff (srst)
    left_wr_end_s |=> left_fresh_s)
    else $error("left settle window of wrong length");

  AST_RIGHT_FRESH: assert property (@(posedge ref_clk) disable iff (srst)
    right_wr_end_s |=> right_fresh_s)
    else $error("right settle window of wrong length");

  AST_PIN_OVERLAP: assert property (@(posedge ref_clk) disable iff (srst)
    (!left_port_select_n && !right_port_select_n) |->
      (left_port_address != right_port_address) || (left_rw && right_rw))
    else $error("both ports selected on one location with a write");

  AST_LEFT_REFUSED: assert property (@(posedge ref_clk) disable iff (srst)
    (right_busy && addr_clash(left_addr, right_port_address, left_we, right_is_write))
      |-> !left_ready)
    else $error("left taken while right used the same location");

  AST_RIGHT_REFUSED: assert property (@(posedge ref_clk) disable iff (srst)
    (left_busy && addr_clash(right_addr, left_port_address, right_we, left_is_write))
      |-> !right_ready)
    else $error("right taken while left used the same location");

endmodule : adprp_host
`default_nettype wire

// ===== tb/adprp_ram_model.sv
`timescale 1ns/1ns
`default_nettype none
module adprp_ram_model #(
  parameter int ACC_NS = 70  // read access from address or select
) (
  // left pins
  input  wire logic        l_sel_n,
  input  wire logic        l_rw,
  input  wire logic        l_oe_n,
  input  wire logic [11:0] l_addr,
  input  wire logic [7:0]  l_din,
  input  wire logic        l_host_drv,
  output logic [7:0]       l_dout,
  output logic             l_drv,
  // right pins
  input  wire logic        r_sel_n,
  input  wire logic        r_rw,
  input  wire logic        r_oe_n,
  input  wire logic [11:0] r_addr,
  input  wire logic [7:0]  r_din,
  input  wire logic        r_host_drv,
  output logic [7:0]       r_dout,
  output logic             r_drv,
  // master misuse seen at the pins
  output var int           viol_count
);
  logic [7:0]  mem [4096];  // one shared array, both ports see it
  logic [7:0]  dq [2];
  int          viol [2];
  wire  [1:0]  sel_n = {r_sel_n, l_sel_n};
  wire  [1:0]  rw    = {r_rw, l_rw};
  wire  [1:0]  oe_n  = {r_oe_n, l_oe_n};
  wire  [1:0]  hdrv  = {r_host_drv, l_host_drv};
  wire  [1:0]  rd;
  wire  [11:0] a [2];
  wire  [7:0]  din [2];

  // pack both sides so one loop serves them
  assign a[0] = l_addr;
  assign a[1] = r_addr;
  assign din[0] = l_din;
  assign din[1] = r_din;

  ////////////////////////////////////////////////////////////////////////
  generate
    for (genvar i = 0; i < 2; i++) begin : g_port
      wire wr = !sel_n[i] && !rw[i];  // overlap of select and write
      // outputs only when selected, reading and enabled
      assign rd[i] = !sel_n[i] && rw[i] && !oe_n[i];
      // level write: opposite port sees it at once; same-address races left open
      always @* if (wr) mem[a[i]] = din[i];
      // data lags any address or control move by the access time, so a hasty
      // sample sees stale bytes; control moves also pick up writes from either side
      always @(a[i] or sel_n or rw or oe_n) dq[i] <= #(ACC_NS) mem[a[i]];
      initial viol[i] = 0;
      // address moving inside a write would corrupt another location
      always @(a[i]) if (wr) viol[i]++;
      always @(hdrv[i] or rd[i]) if (hdrv[i] && rd[i]) viol[i]++;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // drive enables and data toward the bus resolver
  assign l_drv = rd[0];
  assign r_drv = rd[1];
  assign l_dout = dq[0];
  assign r_dout = dq[1];
  assign viol_count = viol[0] + viol[1];
endmodule : adprp_ram_model
`default_nettype wire

// ===== tb/async_dual_port_ram_ports_tb.sv
`timescale 1ns/1ns
`default_nettype none
module async_dual_port_ram_ports_tb;
  typedef struct packed {
    logic        sd;  // 0 left, 1 right
    logic        we;
    logic [11:0] ad;
    logic [7:0]  d;   // byte written, or byte expected back
  } adprp_row_t;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        l_req = 1'b0, l_we = 1'b0, r_req = 1'b0, r_we = 1'b0;
  logic [11:0] l_addr = 12'h000, r_addr = 12'h000, l_paddr, r_paddr;
  logic [7:0]  l_wdata = 8'h00, r_wdata = 8'h00, l_rdata, r_rdata, got, got2;
  logic [7:0]  l_pout, r_pout, l_pin, r_pin, l_dout, r_dout, flt;
  logic        l_ready, l_done, r_ready, r_done, l_sel_n, r_sel_n, l_rw, r_rw;
  logic        l_oe_n, r_oe_n, l_poe_n, r_poe_n, l_drv, r_drv, l_stby, r_stby, fpd;
  int          n_mismatch = 0, check_count = 0, cyc = 0, viol_count;
  wire  [7:0]  idle = {l_sel_n, l_rw, l_oe_n, l_poe_n, r_sel_n, r_rw, r_oe_n, r_poe_n};
  wire  [4:0]  guard = {!l_oe_n && !l_rw, !r_oe_n && !r_rw, !l_sel_n && !l_rw && l_poe_n,
                        !r_sel_n && !r_rw && r_poe_n,
                        !l_sel_n && !r_sel_n && l_paddr == r_paddr && !(l_rw && r_rw)};
  adprp_row_t  rows [8] = '{'{0, 1, 12'h000, 8'ha5}, '{1, 1, 12'hfff, 8'h3c},
                            '{1, 0, 12'h000, 8'ha5}, '{0, 0, 12'hfff, 8'h3c},
                            '{0, 1, 12'h7ff, 8'h00}, '{1, 0, 12'h7ff, 8'h00},
                            '{1, 1, 12'h800, 8'hff}, '{0, 0, 12'h800, 8'hff}};

  always #50 ref_clk = ~ref_clk;

  // wire resolution: host first, then ram, else a byte that moves every cycle
  assign flt = cyc[7:0] ^ 8'h5a;
  assign l_pin = !l_poe_n ? l_pout : (l_drv ? l_dout : flt);
  assign r_pin = !r_poe_n ? r_pout : (r_drv ? r_dout : flt);

  adprp_host dut (.ref_clk(ref_clk), .srst(srst),
    .left_req(l_req), .left_we(l_we), .left_addr(l_addr), .left_wdata(l_wdata),
    .left_ready(l_ready), .left_done(l_done), .left_rdata(l_rdata),
    .right_req(r_req), .right_we(r_we), .right_addr(r_addr), .right_wdata(r_wdata),
    .right_ready(r_ready), .right_done(r_done), .right_rdata(r_rdata),
    .left_port_select_n(l_sel_n), .left_rw(l_rw), .left_oe_n(l_oe_n),
    .left_port_address(l_paddr), .left_port_data_bus_out(l_pout),
    .left_port_data_bus_oe_n(l_poe_n), .left_port_data_bus_in(l_pin),
    .right_port_select_n(r_sel_n), .right_rw(r_rw), .right_oe_n(r_oe_n),
    .right_port_address(r_paddr), .right_port_data_bus_out(r_pout),
    .right_port_data_bus_oe_n(r_poe_n), .right_port_data_bus_in(r_pin),
    .left_standby(l_stby), .right_standby(r_stby), .full_power_down(fpd));

  adprp_ram_model ram (.l_sel_n(l_sel_n), .l_rw(l_rw), .l_oe_n(l_oe_n), .l_addr(l_paddr),
    .l_din(l_pin), .l_host_drv(!l_poe_n), .l_dout(l_dout), .l_drv(l_drv),
    .r_sel_n(r_sel_n), .r_rw(r_rw), .r_oe_n(r_oe_n), .r_addr(r_paddr),
    .r_din(r_pin), .r_host_drv(!r_poe_n), .r_dout(r_dout), .r_drv(r_drv),
    .viol_count(viol_count));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one transfer: request held until taken, then done counted from the taking edge
  task automatic xfer(input logic sd, input logic we, input logic [11:0] ad,
                      input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge ref_clk);
    if (sd) {r_req, r_we, r_addr, r_wdata} = {1'b1, we, ad, wd};
    else {l_req, l_we, l_addr, l_wdata} = {1'b1, we, ad, wd};
    #1;
    while ((sd ? r_ready : l_ready) !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    if (sd) r_req = 1'b0;
    else l_req = 1'b0;
    n = 1;
    while ((sd ? r_done : l_done) !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    check("done latency", 3, n);
    rd = sd ? r_rdata : l_rdata;
  endtask : xfer

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////
  // pin watch every cycle out of reset
  always @(negedge ref_clk) begin
    if (!srst) begin
      check("standby", {l_sel_n, r_sel_n, l_sel_n & r_sel_n}, {l_stby, r_stby, fpd});
      check("write guard", 0, guard);
    end
  end

  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      $display("Error timeout expected finish seen hang");
      end_sim;
    end
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    check("idle pins", 8'hff, idle);
    check("power down", 3'h7, {l_stby, r_stby, fpd});
    srst = 1'b0;
    $display("test reset done");
    foreach (rows[k]) begin
      xfer(rows[k].sd, rows[k].we, rows[k].ad, rows[k].d, got);
      if (!rows[k].we) check("row read", rows[k].d, got);
    end
    $display("test rows done");
    // both sides at once on different locations
    fork
      xfer(1'b0, 1'b1, 12'h010, 8'h81, got);
      xfer(1'b1, 1'b1, 12'h020, 8'h42, got2);
    join
    fork
      xfer(1'b0, 1'b0, 12'h020, 8'h00, got);
      xfer(1'b1, 1'b0, 12'h010, 8'h00, got2);
    join
    check("cross left", 8'h42, got);
    check("cross right", 8'h81, got2);
    $display("test concurrent done");
    // same location from both sides: left wins the tie, then right goes first while its write settles
    xfer(1'b0, 1'b1, 12'h124, 8'h11, got);
    fork
      xfer(1'b0, 1'b0, 12'h124, 8'h00, got);
      xfer(1'b1, 1'b1, 12'h124, 8'h22, got2);
    join
    check("left read first", 8'h11, got);
    fork
      xfer(1'b1, 1'b0, 12'h124, 8'h00, got2);
      xfer(1'b0, 1'b1, 12'h124, 8'h33, got);
    join
    check("right read before write", 8'h22, got2);
    xfer(1'b1, 1'b0, 12'h124, 8'h00, got2);
    check("right after write", 8'h33, got2);
    $display("test clash done");
    // second reset mid-run: pins idle, array untouched
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("idle again", 8'hff, idle);
    srst = 1'b0;
    xfer(1'b1, 1'b0, 12'hfff, 8'h00, got);
    check("kept after reset", 8'h3c, got);
    check("master misuse", 0, viol_count);
    $display("test second reset done");
    end_sim;
  end
endmodule : async_dual_port_ram_ports_tb
`default_nettype wire
